// file: pkg/deac_pkg.sv
// Constants and types shared by the data EEPROM access control block.
package deac_pkg;

    // ****************************************************************
    // Clock and write timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TIME_NS = 4000000;
    localparam int WRITE_CYCLES_DFLT = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int ARRAY_DEPTH = 256;
    localparam int REG_ADDR_W = 3;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [REG_ADDR_W-1:0] OFS_DATA = 3'h0;
    localparam logic [REG_ADDR_W-1:0] OFS_ADDR = 3'h1;
    localparam logic [REG_ADDR_W-1:0] OFS_CTRL = 3'h2;
    localparam logic [REG_ADDR_W-1:0] OFS_UNLOCK = 3'h3;
    localparam logic [REG_ADDR_W-1:0] OFS_FLAG = 3'h4;

    // ****************************************************************
    // Field positions, keys and reset values
    // ****************************************************************
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_PERMIT_BIT = 2;
    localparam int CTRL_ABORT_BIT = 3;
    localparam int FLAG_DONE_BIT = 0;
    localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // ****************************************************************
    // State types
    // ****************************************************************
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_ERASE = 3'b010, ST_PROGRAM = 3'b100} deac_state_type;
    typedef enum logic [2:0] {UL_NONE = 3'b001, UL_KEY1 = 3'b010, UL_KEY2 = 3'b100} deac_unlock_type;

endpackage

// file: hw/deac_byte_array.sv
// Flip-flop storage standing in for the 256-byte nonvolatile array.
`timescale 1ns/1ps
module deac_byte_array (
    input wire logic sys_clk_in,
    input wire logic we_in,
    input wire logic [deac_pkg::ADDR_W-1:0] waddr_in,
    input wire logic [deac_pkg::DATA_W-1:0] wdata_in,
    input wire logic [deac_pkg::ADDR_W-1:0] core_addr_in,
    output logic [deac_pkg::DATA_W-1:0] core_data_out,
    input wire logic [deac_pkg::ADDR_W-1:0] prog_addr_in,
    output logic [deac_pkg::DATA_W-1:0] prog_data_out
);
    import deac_pkg::*;

    logic [DATA_W-1:0] mem_ff [ARRAY_DEPTH];

    // ****************************************************************
    // Storage
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (we_in) begin
            mem_ff[waddr_in] <= wdata_in;
        end
    end

    assign core_data_out = mem_ff[core_addr_in];
    assign prog_data_out = mem_ff[prog_addr_in];

endmodule

// file: hw/deac_unlock_seq.sv
// Detector for the two-key write initiation sequence on the unlock port.
`timescale 1ns/1ps
module deac_unlock_seq (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic any_strobe_in,
    input wire logic key_write_in,
    input wire logic [deac_pkg::DATA_W-1:0] wdata_in,
    output logic armed_out
);
    import deac_pkg::*;

    deac_unlock_type stage_ff;

    // ****************************************************************
    // Key tracking, broken by any other strobe or an idle cycle
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_ff <= UL_NONE;
        end else if (clear_in) begin
            stage_ff <= UL_NONE;
        end else if (key_write_in && wdata_in == UNLOCK_KEY1) begin
            stage_ff <= UL_KEY1;
        end else if (key_write_in && wdata_in == UNLOCK_KEY2 && stage_ff == UL_KEY1) begin
            stage_ff <= UL_KEY2;
        end else if (any_strobe_in || stage_ff != UL_NONE) begin
            stage_ff <= UL_NONE;
        end
    end

    assign armed_out = (stage_ff == UL_KEY2);

    sequence key1_s;
        key_write_in && wdata_in == UNLOCK_KEY1 && !clear_in;
    endsequence

    sequence key2_s;
        key_write_in && wdata_in == UNLOCK_KEY2 && !clear_in;
    endsequence

    unlock_arms_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        key1_s ##1 key2_s |=> armed_out)
        else $error("Unlock keys in order did not arm the write.");

    armed_cause_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        armed_out |-> $past(key_write_in) && $past(wdata_in) == UNLOCK_KEY2)
        else $error("Write armed without the second key.");

endmodule

// file: hw/deac_top.sv
// Data EEPROM access control: registers, unlock, erase-program cycle and programmer port.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Array holds 256 bytes, addressed by an 8-bit address register.
// - Data register is 8 bits: byte to write or byte last read.
// - Each core write erases the location first, then programs the new byte; a programmer write stores its byte with no erase.
// - Write duration is timed by an internal counter.
// - With protection on, the core keeps access; the programmer reads zeros.
// - Only control bits 3 to 0 exist; bits 7 to 4 read zero.
// - Read and write request bits are set-only; hardware clears them.
// - Write permit gates write cycles and is clear after power-up.
// - Abort flag is set when a reset cuts a write short; software clears it.
// - Any reset clears data and address registers.
// - Write completion sets the done flag; only software clears it.
// - Unlock port stores nothing and reads zero.
// - A read requested while idle loads the data register in one cycle; one requested during a write waits until the write ends.
// - Data register keeps its byte until another read, a software write or a reset.
// - Write starts only after 55h, AAh, then write request, back to back.
// - Write request cannot be set unless permit is already set.
// - Clearing permit during a write does not disturb it.
// - Hardware never clears permit at the end of a write.
module deac_top #(
    parameter int WRITE_CYCLES = deac_pkg::WRITE_CYCLES_DFLT
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic ext_reset_in,
    input wire logic watchdog_timeout_in,
    input wire logic brownout_reset_in,
    input wire logic [deac_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [deac_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [deac_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic data_protect_in,
    input wire logic prog_rd_in,
    input wire logic prog_wr_in,
    input wire logic [deac_pkg::ADDR_W-1:0] prog_addr_in,
    input wire logic [deac_pkg::DATA_W-1:0] prog_wdata_in,
    output logic [deac_pkg::DATA_W-1:0] prog_rdata_out,
    output logic write_busy_out,
    output logic write_done_flag_out
);
    import deac_pkg::*;

    localparam logic [TIMER_W-1:0] LAST_TICK = TIMER_W'(WRITE_CYCLES - 2);

    deac_state_type state_ff;
    deac_state_type nxt_state;
    logic [DATA_W-1:0] data_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic rd_ff;
    logic wr_ff;
    logic permit_ff;
    logic abort_ff;
    logic done_ff;
    logic busy_ff;
    logic [TIMER_W-1:0] timer_ff;
    logic [ADDR_W-1:0] wr_addr_ff;
    logic [DATA_W-1:0] wr_data_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] prog_rdata_ff;
    logic sync_reset;
    logic ctrl_wr;
    logic armed;
    logic start_write;
    logic finish_write;
    logic idle;
    logic rd_now;
    logic arr_we;
    logic [ADDR_W-1:0] arr_waddr;
    logic [DATA_W-1:0] arr_wdata;
    logic [DATA_W-1:0] core_rdata;
    logic [DATA_W-1:0] prog_arr_rdata;
    logic prog_write;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    assign sync_reset = ext_reset_in || watchdog_timeout_in || brownout_reset_in;
    assign ctrl_wr = reg_wr_in && reg_addr_in == OFS_CTRL;
    assign idle = (state_ff == ST_IDLE);
    assign start_write = ctrl_wr && reg_wdata_in[CTRL_WR_BIT] && armed && permit_ff && idle && !sync_reset;
    assign finish_write = (state_ff == ST_PROGRAM) && timer_ff == LAST_TICK && !sync_reset;
    assign rd_now = idle && !start_write && !sync_reset && (rd_ff || (ctrl_wr && reg_wdata_in[CTRL_RD_BIT]));
    assign prog_write = prog_wr_in && !data_protect_in && idle && !start_write && !sync_reset;

    deac_unlock_seq u_unlock (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(sync_reset),
        .any_strobe_in(reg_wr_in || reg_rd_in),
        .key_write_in(reg_wr_in && reg_addr_in == OFS_UNLOCK),
        .wdata_in(reg_wdata_in),
        .armed_out(armed)
    );

    // ****************************************************************
    // Array write port: erase, program, programmer write
    // ****************************************************************
    always_comb begin
        arr_we = 1'b0;
        arr_waddr = wr_addr_ff;
        arr_wdata = ERASED_BYTE;
        if (state_ff == ST_ERASE && !sync_reset) begin
            arr_we = 1'b1;
        end else if (finish_write) begin
            arr_we = 1'b1;
            arr_wdata = wr_data_ff;
        end else if (prog_write) begin
            arr_we = 1'b1;
            arr_waddr = prog_addr_in;
            arr_wdata = prog_wdata_in;
        end
    end

    deac_byte_array u_array (
        .sys_clk_in(sys_clk_in),
        .we_in(arr_we),
        .waddr_in(arr_waddr),
        .wdata_in(arr_wdata),
        .core_addr_in(addr_ff),
        .core_data_out(core_rdata),
        .prog_addr_in(prog_addr_in),
        .prog_data_out(prog_arr_rdata)
    );

    // ****************************************************************
    // Write cycle sequencer
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_write) begin
                    nxt_state = ST_ERASE;
                end
            end
            ST_ERASE: begin
                nxt_state = ST_PROGRAM;
            end
            ST_PROGRAM: begin
                if (finish_write) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (sync_reset) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_ff <= '0;
        end else if (state_ff == ST_PROGRAM && !finish_write && !sync_reset) begin
            timer_ff <= timer_ff + 1'b1;
        end else begin
            timer_ff <= '0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_addr_ff <= ADDR_RESET;
            wr_data_ff <= DATA_RESET;
        end else if (start_write) begin
            wr_addr_ff <= addr_ff;
            wr_data_ff <= data_ff;
        end
    end

    // ****************************************************************
    // Data and address registers
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_ff <= DATA_RESET;
        end else if (sync_reset) begin
            data_ff <= DATA_RESET;
        end else if (rd_now) begin
            data_ff <= core_rdata;
        end else if (reg_wr_in && reg_addr_in == OFS_DATA) begin
            data_ff <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_ff <= ADDR_RESET;
        end else if (sync_reset) begin
            addr_ff <= ADDR_RESET;
        end else if (reg_wr_in && reg_addr_in == OFS_ADDR) begin
            addr_ff <= reg_wdata_in;
        end
    end

    // ****************************************************************
    // Control bits
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_ff <= 1'b0;
        end else if (sync_reset || rd_now) begin
            rd_ff <= 1'b0;
        end else if (ctrl_wr && reg_wdata_in[CTRL_RD_BIT]) begin
            rd_ff <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ff <= 1'b0;
        end else if (sync_reset || finish_write) begin
            wr_ff <= 1'b0;
        end else if (start_write) begin
            wr_ff <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            permit_ff <= 1'b0;
        end else if (sync_reset) begin
            permit_ff <= 1'b0;
        end else if (ctrl_wr) begin
            permit_ff <= reg_wdata_in[CTRL_PERMIT_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            abort_ff <= 1'b0;
        end else if (sync_reset && !idle) begin
            abort_ff <= 1'b1;
        end else if (ctrl_wr) begin
            abort_ff <= reg_wdata_in[CTRL_ABORT_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_ff <= 1'b0;
        end else if (finish_write) begin
            done_ff <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == OFS_FLAG && !reg_wdata_in[FLAG_DONE_BIT]) begin
            done_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Register read port and programmer read port
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= ZERO_BYTE;
        end else if (!reg_rd_in) begin
            rdata_ff <= ZERO_BYTE;
        end else if (reg_addr_in == OFS_DATA) begin
            rdata_ff <= data_ff;
        end else if (reg_addr_in == OFS_ADDR) begin
            rdata_ff <= addr_ff;
        end else if (reg_addr_in == OFS_CTRL) begin
            rdata_ff <= {4'h0, abort_ff, permit_ff, wr_ff, rd_ff};
        end else if (reg_addr_in == OFS_FLAG) begin
            rdata_ff <= {7'h00, done_ff};
        end else begin
            rdata_ff <= ZERO_BYTE;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prog_rdata_ff <= ZERO_BYTE;
        end else if (prog_rd_in && !data_protect_in) begin
            prog_rdata_ff <= prog_arr_rdata;
        end else if (prog_rd_in) begin
            prog_rdata_ff <= ZERO_BYTE;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign prog_rdata_out = prog_rdata_ff;
    assign write_busy_out = busy_ff;
    assign write_done_flag_out = done_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking main_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence read_req_s;
        ctrl_wr && reg_wdata_in[CTRL_RD_BIT] && idle && !start_write && !sync_reset;
    endsequence

    read_one_cycle_a: assert property (read_req_s |=> data_ff == $past(core_rdata) && !rd_ff)
        else $error("Read did not load the data register in one cycle.");

    read_waits_a: assert property (rd_ff && !idle && !sync_reset |=> rd_ff && data_ff == $past(data_ff)
        || $past(reg_wr_in))
        else $error("Pending read was served during a write.");

    permit_gate_a: assert property (idle && !permit_ff |=> idle)
        else $error("Write started without permit.");

    erase_then_prog_a: assert property (state_ff == ST_ERASE && !sync_reset |-> arr_we
        && arr_wdata == ERASED_BYTE ##1 state_ff == ST_PROGRAM)
        else $error("Erase did not lead into programming.");

    timer_bound_a: assert property (state_ff == ST_PROGRAM |-> timer_ff <= LAST_TICK)
        else $error("Write timer ran past its length.");

    done_sets_a: assert property (finish_write |=> done_ff && !wr_ff && permit_ff == $past(permit_ff))
        else $error("Write end did not set done or altered permit.");

    abort_sets_a: assert property (sync_reset && !idle |=> abort_ff && idle && data_ff == DATA_RESET)
        else $error("Reset during write did not flag the abort.");

    unlock_zero_a: assert property (reg_rd_in && reg_addr_in == OFS_UNLOCK |=> reg_rdata_out == ZERO_BYTE)
        else $error("Unlock port read was not zero.");

    ctrl_upper_a: assert property (reg_rd_in && reg_addr_in == OFS_CTRL |=> reg_rdata_out[7:4] == 4'h0)
        else $error("Control upper bits read nonzero.");

    protect_zero_a: assert property (prog_rd_in && data_protect_in |=> prog_rdata_out == ZERO_BYTE)
        else $error("Protected array leaked to programmer.");

    permit_hold_a: assert property (!idle && !ctrl_wr && !sync_reset |=> permit_ff == $past(permit_ff))
        else $error("Permit changed by hardware.");

endmodule

// file: bench/deac_core_model.sv
// Processor core model that issues register bus accesses to the block.
`timescale 1ns/1ps
module deac_core_model (
    input wire logic sys_clk_in,
    output logic [deac_pkg::REG_ADDR_W-1:0] reg_addr_out,
    output logic [deac_pkg::DATA_W-1:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [deac_pkg::DATA_W-1:0] reg_rdata_in
);
    import deac_pkg::*;
    initial begin
        reg_addr_out = 3'h0;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end
    // ********
    // Bus cycles
    // ********
    // The write strobe stays high so that writes may follow with no gap.
    task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
        @(posedge sys_clk_in);
        reg_addr_out <= ad;
        reg_wdata_out <= dt;
        reg_wr_out <= 1'b1;
        reg_rd_out <= 1'b0;
    endtask
    // Released write data is inverted so that stale values cannot pass.
    task automatic idle();
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b0;
        reg_rd_out <= 1'b0;
        reg_wdata_out <= ~reg_wdata_out;
    endtask
    task automatic w(input logic [2:0] ad, input logic [7:0] dt);
        wr(ad, dt);
        idle();
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [2:0] ad, output logic [7:0] dt);
        @(posedge sys_clk_in);
        reg_addr_out <= ad;
        reg_rd_out <= 1'b1;
        reg_wr_out <= 1'b0;
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b0;
        @(negedge sys_clk_in);
        dt = reg_rdata_in;
    endtask
endmodule

// file: bench/deac_bench.sv
// Self-checking bench for the data EEPROM access control block.
`timescale 1ns/1ps
module deac_bench;
    import deac_pkg::*;
    localparam int WCYC = 8;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] sreset = 3'h0;
    logic [REG_ADDR_W-1:0] ra;
    logic [7:0] rwd;
    logic [7:0] rrd;
    logic [7:0] prd;
    logic rw;
    logic rr;
    logic busy;
    logic done;
    logic protect = 1'b0;
    logic prog_rd = 1'b0;
    logic prog_wr = 1'b0;
    logic [7:0] prog_wd = 8'h00;
    logic [7:0] prog_addr = 8'h00;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int busy_cyc = 0;
    int s;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] v;
    always #20 sys_clk_in = ~sys_clk_in;
    deac_top #(.WRITE_CYCLES(WCYC)) deac_top_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .ext_reset_in(sreset[0]), .watchdog_timeout_in(sreset[1]), .brownout_reset_in(sreset[2]),
        .reg_addr_in(ra), .reg_wdata_in(rwd), .reg_wr_in(rw), .reg_rd_in(rr), .reg_rdata_out(rrd),
        .data_protect_in(protect), .prog_rd_in(prog_rd), .prog_wr_in(prog_wr), .prog_addr_in(prog_addr),
        .prog_wdata_in(prog_wd), .prog_rdata_out(prd), .write_busy_out(busy), .write_done_flag_out(done));
    deac_core_model deac_core_model_i (.sys_clk_in(sys_clk_in), .reg_addr_out(ra), .reg_wdata_out(rwd),
        .reg_wr_out(rw), .reg_rd_out(rr), .reg_rdata_in(rrd));
    // ********
    // Helpers
    // ********
    task automatic finish_test();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] ctl_exp(input logic abort, input logic permit);
        return {4'h0, abort, permit, 2'b00};
    endfunction
    task automatic rdc(input logic [2:0] ad, input logic [7:0] exp);
        deac_core_model_i.rd(ad, v);
        chk(v, exp);
    endtask
    task automatic load(input logic [7:0] ad, input logic [7:0] dt);
        deac_core_model_i.w(OFS_CTRL, 8'h04);
        deac_core_model_i.w(OFS_ADDR, ad);
        deac_core_model_i.w(OFS_DATA, dt);
    endtask
    task automatic ulk(input logic [7:0] k1, input logic [7:0] ctl);
        deac_core_model_i.wr(OFS_UNLOCK, k1);
        deac_core_model_i.wr(OFS_UNLOCK, UNLOCK_KEY2);
        deac_core_model_i.wr(OFS_CTRL, ctl);
        deac_core_model_i.idle();
        @(negedge sys_clk_in);
    endtask
    task automatic pread(input logic [7:0] ad, input logic p, input logic [7:0] exp);
        @(posedge sys_clk_in);
        prog_addr <= ad;
        protect <= p;
        prog_rd <= 1'b1;
        @(posedge sys_clk_in);
        prog_rd <= 1'b0;
        @(negedge sys_clk_in);
        chk(prd, exp);
    endtask
    // One programmer write strobe; it lands only while unprotected and idle.
    task automatic pwrite(input logic [7:0] ad, input logic p, input logic [7:0] dt);
        @(posedge sys_clk_in);
        prog_addr <= ad;
        protect <= p;
        prog_wd <= dt;
        prog_wr <= 1'b1;
        @(posedge sys_clk_in);
        prog_wr <= 1'b0;
    endtask
    // Counts busy cycles and cuts a hang short.
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (busy === 1'b1) begin
            busy_cyc <= busy_cyc + 1;
        end
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    // ********
    // Scenarios
    // ********
    initial begin
        s = $urandom(50996);
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rdc(i[2:0], 8'h00);
        end
        for (int i = 0; i < 3; i++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            load(a, d);
            busy_cyc = 0;
            ulk(UNLOCK_KEY1, 8'h06);
            chk({7'h0, busy}, 8'h01);
            pread(a, 1'b0, ERASED_BYTE);
            if (i == 1) begin
                deac_core_model_i.w(OFS_CTRL, 8'h00);
            end else if (i == 2) begin
                deac_core_model_i.w(OFS_CTRL, 8'h05);
                rdc(OFS_CTRL, 8'h07);
            end
            for (int k = 0; k < 40 && busy === 1'b1; k++) begin
                @(negedge sys_clk_in);
            end
            chk(busy_cyc[7:0], 8'(WCYC));
            chk({7'h0, done}, 8'h01);
            rdc(OFS_CTRL, ctl_exp(1'b0, i != 1));
            deac_core_model_i.w(OFS_DATA, ~d);
            deac_core_model_i.w(OFS_CTRL, 8'h05);
            rdc(OFS_DATA, d);
            rdc(OFS_CTRL, 8'h04);
            rdc(OFS_DATA, d);
            s = $urandom_range(1);
            pread(a, s[0], s[0] ? ZERO_BYTE : d);
            pwrite(a, s[0], ~d);
            pread(a, 1'b0, s[0] ? d : ~d);
            deac_core_model_i.w(OFS_FLAG, 8'h00);
            rdc(OFS_FLAG, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            load(8'h3c, 8'h5a);
            if (i == 0) begin
                deac_core_model_i.w(OFS_CTRL, 8'h00);
            end
            if (i == 3) begin
                deac_core_model_i.w(OFS_UNLOCK, UNLOCK_KEY1);
                deac_core_model_i.w(OFS_UNLOCK, UNLOCK_KEY2);
                deac_core_model_i.w(OFS_CTRL, 8'h06);
                @(negedge sys_clk_in);
            end else begin
                ulk(i == 1 ? 8'h54 : (i == 2 ? UNLOCK_KEY2 : UNLOCK_KEY1), 8'h06);
            end
            chk({7'h0, busy}, 8'h00);
            rdc(OFS_CTRL, 8'h04);
        end
        for (int i = 0; i < 3; i++) begin
            load(8'h11, 8'h22);
            ulk(UNLOCK_KEY1, 8'h06);
            @(posedge sys_clk_in);
            sreset <= 3'h1 << i;
            @(posedge sys_clk_in);
            sreset <= 3'h0;
            rdc(OFS_CTRL, ctl_exp(1'b1, 1'b0));
            rdc(OFS_ADDR, 8'h00);
            rdc(OFS_DATA, 8'h00);
            chk({7'h0, busy}, 8'h00);
            deac_core_model_i.w(OFS_CTRL, 8'h00);
            rdc(OFS_CTRL, 8'h00);
        end
        finish_test();
    end
endmodule
